// [common/sfe_pkg.sv]
package sfe_pkg;
   // Supported read opcodes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OP_QUAD_IO = 8'hEB;
   // Frame field sizes in bits
   localparam int OPC_BITS = 8;
   localparam int ADDR_BITS = 24;
   localparam int ARRAY_AW = 19;
   localparam int MODE_BITS = 8;
   // Dummy clock counts
   localparam logic [4:0] DUMMY_NONE = 5'h00;
   localparam logic [4:0] DUMMY_FAST = 5'h08;
   localparam logic [4:0] DUMMY_QUAD_IO = 5'h04;
   // Mode bits [5:4] that keep the next frame opcode-free
   localparam logic [1:0] CONT_MODE = 2'h2;
   // Lane width as log2 of the number of lines
   localparam logic [1:0] LW_1 = 2'h0;
   localparam logic [1:0] LW_2 = 2'h1;
   localparam logic [1:0] LW_4 = 2'h2;
   // Read data buffer
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 32;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_OPC = 7'h02,
      ST_ADDR = 7'h04,
      ST_MODE = 7'h08,
      ST_DUMMY = 7'h10,
      ST_DATA = 7'h20,
      ST_IGNORE = 7'h40
   } sfe_state_type;
endpackage

// [logic/sfe_fifo.sv]
`timescale 1ns/1ps
module sfe_fifo #(
   parameter int WIDTH = sfe_pkg::FIFO_W,
   parameter int DEPTH = sfe_pkg::FIFO_D
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_flush,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   // Pointers wrap naturally, so DEPTH must be a power of two
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic in_ready_q;
   logic out_valid_q;
   logic push;
   logic pop;

   assign push = i_in_valid & in_ready_q & ~i_flush;
   assign pop = i_out_ready & out_valid_q & ~i_flush;
   assign o_in_ready = in_ready_q;
   assign o_out_valid = out_valid_q;
   assign o_out_data = mem_q[rp_q];

   always_comb begin
      if (i_flush) begin
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         in_ready_q <= 1'b1;
         out_valid_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         in_ready_q <= (cnt_d != FULL_CNT);
         out_valid_q <= (cnt_d != '0);
         if (i_flush) begin
            wp_q <= '0;
            rp_q <= '0;
         end else begin
            if (push) begin
               wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
               rp_q <= rp_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wp_q] <= i_in_data;
      end
   end
endmodule

// [logic/sfe_flash_front.sv]
`timescale 1ns/1ps
// Behaviour
// - Only modes 0 and 3; sample on clock rise, drive on clock fall.
// - Dual-output read drives two data bits per clock on SI and SO.
// - Dual I/O read: opcode on SI, address and data on two lines.
// - Quad-output read drives four data bits per clock on all four lines.
// - Quad I/O read: address in on four lines, data out on four lines.
// - All opcode, address and data bits travel most significant bit first.
// - Chip select deassertion ends the current operation.
// - An unsupported opcode starts no operation.
// - After an unsupported opcode, input is ignored until chip select toggles.
// - Chip select lost before opcode and address complete returns to idle.
// - Address bits 23 to 19 are ignored; 19 low bits select a location.
// - Fast, dual-output and quad-output reads insert 8 dummy clocks, no mode bits.
// - Dual I/O read has 4 mode clocks, no dummy, and a continuous form.
// - Quad I/O read has 2 mode clocks, 4 dummy clocks, and a continuous form.
module sfe_flash_front #(
   parameter int FIFO_DEPTH = sfe_pkg::FIFO_D
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Serial link pins
   input wire logic i_cs_b,
   input wire logic i_sck,
   input wire logic [3:0] i_io,
   output logic [3:0] o_io_out,
   output logic [3:0] o_io_oe,
   // Array read side
   output logic [sfe_pkg::ARRAY_AW-1:0] o_rd_addr,
   output logic o_rd_start,
   output logic o_frame_end,
   output logic o_underrun,
   input wire logic i_rd_valid,
   input wire logic [sfe_pkg::FIFO_W-1:0] i_rd_data,
   output logic o_rd_ready
);
   sfe_pkg::sfe_state_type state_q;
   logic cs_s1_q, cs_s2_q;
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic [3:0] io_s1_q, io_s2_q;
   logic cs_act, sck_rise, sck_fall;
   logic [4:0] cnt_q;
   logic [23:0] sh_q;
   logic [23:0] sh_d;
   logic [7:0] opc;
   logic [1:0] alw_q, dlw_q;
   logic [4:0] dum_q;
   logic has_mode_q, cont_q;
   logic rd_start_q, frame_end_q, underrun_q;
   logic [sfe_pkg::ARRAY_AW-1:0] rd_addr_q;
   logic [3:0] out_q, oe_q;
   logic [7:0] ob_q, src;
   logic [3:0] obit_q, lanes;
   logic pop, fifo_valid;
   logic [7:0] fifo_data;

   // Pins are asynchronous to i_clk; the first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         io_s1_q <= 4'h0;
         io_s2_q <= 4'h0;
      end else begin
         cs_s1_q <= i_cs_b;
         cs_s2_q <= cs_s1_q;
         sck_s1_q <= i_sck;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         io_s1_q <= i_io;
         io_s2_q <= io_s1_q;
      end
   end

   assign cs_act = ~cs_s2_q;
   // Mode 3 idles high, so no edge is seen at select; both modes share one path
   assign sck_rise = cs_act & sck_s2_q & ~sck_s3_q;
   assign sck_fall = cs_act & ~sck_s2_q & sck_s3_q;

   // Higher line carries the more significant bit
   always_comb begin
      case (state_q == sfe_pkg::ST_OPC ? sfe_pkg::LW_1 : alw_q)
         sfe_pkg::LW_1: sh_d = {sh_q[22:0], io_s2_q[0]};
         sfe_pkg::LW_2: sh_d = {sh_q[21:0], io_s2_q[1:0]};
         default: sh_d = {sh_q[19:0], io_s2_q};
      endcase
   end
   assign opc = sh_d[7:0];

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_q <= sfe_pkg::ST_IDLE;
         cnt_q <= 5'h00;
         sh_q <= 24'h000000;
         alw_q <= sfe_pkg::LW_1;
         dlw_q <= sfe_pkg::LW_1;
         dum_q <= sfe_pkg::DUMMY_NONE;
         has_mode_q <= 1'b0;
         cont_q <= 1'b0;
         rd_start_q <= 1'b0;
         rd_addr_q <= '0;
         frame_end_q <= 1'b0;
      end else begin
         rd_start_q <= 1'b0;
         frame_end_q <= 1'b0;
         if (!cs_act) begin
            frame_end_q <= (state_q != sfe_pkg::ST_IDLE);
            state_q <= sfe_pkg::ST_IDLE;
            cnt_q <= 5'h00;
         end else begin
            case (state_q)
               sfe_pkg::ST_IDLE: begin
                  // Continuous read skips the opcode and reuses the last command
                  state_q <= cont_q ? sfe_pkg::ST_ADDR : sfe_pkg::ST_OPC;
               end
               sfe_pkg::ST_OPC: if (sck_rise) begin
                  sh_q <= sh_d;
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'(sfe_pkg::OPC_BITS - 1)) begin
                     cnt_q <= 5'h00;
                     state_q <= sfe_pkg::ST_ADDR;
                     has_mode_q <= 1'b0;
                     alw_q <= sfe_pkg::LW_1;
                     dum_q <= sfe_pkg::DUMMY_FAST;
                     case (opc)
                        sfe_pkg::OP_READ: begin
                           dlw_q <= sfe_pkg::LW_1;
                           dum_q <= sfe_pkg::DUMMY_NONE;
                        end
                        sfe_pkg::OP_FAST: dlw_q <= sfe_pkg::LW_1;
                        sfe_pkg::OP_DUAL_OUT: dlw_q <= sfe_pkg::LW_2;
                        sfe_pkg::OP_QUAD_OUT: dlw_q <= sfe_pkg::LW_4;
                        sfe_pkg::OP_DUAL_IO: begin
                           alw_q <= sfe_pkg::LW_2;
                           dlw_q <= sfe_pkg::LW_2;
                           has_mode_q <= 1'b1;
                           dum_q <= sfe_pkg::DUMMY_NONE;
                        end
                        sfe_pkg::OP_QUAD_IO: begin
                           alw_q <= sfe_pkg::LW_4;
                           dlw_q <= sfe_pkg::LW_4;
                           has_mode_q <= 1'b1;
                           dum_q <= sfe_pkg::DUMMY_QUAD_IO;
                        end
                        default: state_q <= sfe_pkg::ST_IGNORE;
                     endcase
                  end
               end
               sfe_pkg::ST_ADDR: if (sck_rise) begin
                  sh_q <= sh_d;
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'((sfe_pkg::ADDR_BITS >> alw_q) - 1)) begin
                     cnt_q <= 5'h00;
                     rd_addr_q <= sh_d[sfe_pkg::ARRAY_AW-1:0];
                     rd_start_q <= 1'b1;
                     if (has_mode_q) begin
                        state_q <= sfe_pkg::ST_MODE;
                     end else if (dum_q != sfe_pkg::DUMMY_NONE) begin
                        state_q <= sfe_pkg::ST_DUMMY;
                     end else begin
                        state_q <= sfe_pkg::ST_DATA;
                     end
                  end
               end
               sfe_pkg::ST_MODE: if (sck_rise) begin
                  sh_q <= sh_d;
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'((sfe_pkg::MODE_BITS >> alw_q) - 1)) begin
                     cnt_q <= 5'h00;
                     cont_q <= (sh_d[5:4] == sfe_pkg::CONT_MODE);
                     state_q <= (dum_q != sfe_pkg::DUMMY_NONE) ? sfe_pkg::ST_DUMMY : sfe_pkg::ST_DATA;
                  end
               end
               sfe_pkg::ST_DUMMY: if (sck_rise) begin
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == dum_q - 5'h01) begin
                     cnt_q <= 5'h00;
                     state_q <= sfe_pkg::ST_DATA;
                  end
               end
               // Data and ignore both hold until select is released
               sfe_pkg::ST_DATA: state_q <= sfe_pkg::ST_DATA;
               sfe_pkg::ST_IGNORE: state_q <= sfe_pkg::ST_IGNORE;
               default: state_q <= sfe_pkg::ST_IDLE;
            endcase
         end
      end
   end

   assign lanes = 4'(1 << dlw_q);
   assign pop = (state_q == sfe_pkg::ST_DATA) && sck_fall && (obit_q == 4'h0);
   // An empty buffer cannot stall the host's clock, so zeros go out instead
   assign src = (obit_q != 4'h0) ? ob_q : (fifo_valid ? fifo_data : 8'h00);

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         out_q <= 4'h0;
         oe_q <= 4'h0;
         ob_q <= 8'h00;
         obit_q <= 4'h0;
         underrun_q <= 1'b0;
      end else begin
         underrun_q <= pop & ~fifo_valid;
         if (state_q != sfe_pkg::ST_DATA || !cs_act) begin
            oe_q <= 4'h0;
            obit_q <= 4'h0;
         end else if (sck_fall) begin
            ob_q <= 8'(src << lanes);
            obit_q <= ((obit_q == 4'h0) ? 4'h8 : obit_q) - lanes;
            case (dlw_q)
               sfe_pkg::LW_1: begin
                  out_q <= {2'b00, src[7], 1'b0};
                  oe_q <= 4'h2;
               end
               sfe_pkg::LW_2: begin
                  out_q <= {2'b00, src[7:6]};
                  oe_q <= 4'h3;
               end
               default: begin
                  out_q <= src[7:4];
                  oe_q <= 4'hF;
               end
            endcase
         end
      end
   end

   // Select released flushes stale bytes so they never reach the next frame
   sfe_fifo #(
      .WIDTH(sfe_pkg::FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_flush(~cs_act),
      .i_in_valid(i_rd_valid),
      .i_in_data(i_rd_data),
      .o_in_ready(o_rd_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(fifo_data),
      .i_out_ready(pop)
   );

   assign o_io_out = out_q;
   assign o_io_oe = oe_q;
   assign o_rd_addr = rd_addr_q;
   assign o_rd_start = rd_start_q;
   assign o_frame_end = frame_end_q;
   assign o_underrun = underrun_q;

   sequence s_opc_done;
      (state_q == sfe_pkg::ST_OPC) && sck_rise && (cnt_q == 5'h07);
   endsequence

   a_opc_length: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      s_opc_done |=> (state_q != sfe_pkg::ST_OPC))
      else $error("opcode phase did not end after eight clocks");
   a_cs_abort: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !cs_act |=> (state_q == sfe_pkg::ST_IDLE) && (o_io_oe == 4'h0))
      else $error("frame not abandoned on select release");
   a_ignore_stick: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_q == sfe_pkg::ST_IGNORE) && cs_act |=> (state_q == sfe_pkg::ST_IGNORE))
      else $error("ignore state left while selected");
   a_unsup_nostart: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_q == sfe_pkg::ST_IGNORE) |-> !o_rd_start && (o_io_oe == 4'h0))
      else $error("unsupported opcode started an operation");
   a_oe_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_io_oe != 4'h0) |-> (state_q == sfe_pkg::ST_DATA))
      else $error("lines driven outside the data phase");
   a_drive_fall: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $changed(o_io_out) |-> $past(sck_fall))
      else $error("output changed without a falling clock");
   a_lane_dual: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_io_oe != 4'h0) && (dlw_q == sfe_pkg::LW_2) |-> (o_io_oe == 4'h3))
      else $error("dual read not on two lines");
   a_lane_quad: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_io_oe != 4'h0) && (dlw_q == sfe_pkg::LW_4) |-> (o_io_oe == 4'hF))
      else $error("quad read not on four lines");
   a_addr_trunc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_rd_start |-> (o_rd_addr == sh_q[18:0]) ##1 !o_rd_start)
      else $error("read address not the low address bits");
endmodule

// [dv/sfe_host_model.sv]
`timescale 1ns/1ps
module sfe_host_model #(
   parameter int HALF = 6
) (
   // Clock
   input wire logic i_clk,
   // Resolved data pins
   input wire logic [3:0] i_io,
   // Host-driven pins
   output logic o_cs_b,
   output logic o_sck,
   output logic [3:0] o_io
);
   initial begin
      o_cs_b = 1'b1;
      o_sck = 1'b0;
      o_io = 4'h0;
   end

   // Select falls a full half period ahead of the first edge so the synchroniser sees it first
   task automatic start(input bit mode3);
      @(posedge i_clk);
      o_sck <= mode3;
      repeat (HALF) @(posedge i_clk);
      o_cs_b <= 1'b0;
      repeat (HALF) @(posedge i_clk);
   endtask

   // Drives on the fall, samples on the rise; unused lines toggle as a released bus would
   task automatic xfer(input int lanes, input int nbits, input logic [31:0] din, output logic [31:0] dout);
      logic [3:0] mask;
      mask = 4'((1 << lanes) - 1);
      dout = 32'h0;
      for (int i = nbits - lanes; i >= 0; i -= lanes) begin
         @(posedge i_clk);
         o_sck <= 1'b0;
         o_io <= (~o_io & ~mask) | (4'(din >> i) & mask);
         repeat (HALF) @(posedge i_clk);
         o_sck <= 1'b1;
         dout = (dout << lanes) | 32'((lanes == 1) ? {3'h0, i_io[1]} : (i_io & mask));
         repeat (HALF - 1) @(posedge i_clk);
      end
   endtask

   // Mode 0 ends with the clock low, mode 3 with it high
   task automatic stop(input bit mode3);
      @(posedge i_clk);
      o_sck <= mode3;
      repeat (HALF) @(posedge i_clk);
      o_cs_b <= 1'b1;
      o_io <= ~o_io;
      repeat (2 * HALF) @(posedge i_clk);
   endtask
endmodule

// [dv/sfe_flash_front_tb_top.sv]
`timescale 1ns/1ps
module sfe_flash_front_tb_top;
   localparam int DEPTH = sfe_pkg::FIFO_D;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic rd_valid = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic cs_b;
   logic sck;
   logic [3:0] host_io;
   logic [3:0] io_out;
   logic [3:0] io_oe;
   logic [3:0] pin_io;
   logic [18:0] rd_addr;
   logic [18:0] start_addr = 19'h0;
   logic rd_start;
   logic frame_end;
   logic underrun;
   logic rd_ready;
   int n_errors = 0;
   int n_tests = 0;
   int n_start = 0;
   int n_end = 0;
   int n_under = 0;

   always #2 i_clk = ~i_clk;

   assign pin_io = (io_oe & io_out) | (~io_oe & host_io);

   sfe_host_model #(
      .HALF(6)
   ) sfe_host_model_inst (
      .i_clk(i_clk),
      .i_io(pin_io),
      .o_cs_b(cs_b),
      .o_sck(sck),
      .o_io(host_io)
   );

   sfe_flash_front #(
      .FIFO_DEPTH(DEPTH)
   ) sfe_flash_front_inst (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_cs_b(cs_b),
      .i_sck(sck),
      .i_io(pin_io),
      .o_io_out(io_out),
      .o_io_oe(io_oe),
      .o_rd_addr(rd_addr),
      .o_rd_start(rd_start),
      .o_frame_end(frame_end),
      .o_underrun(underrun),
      .i_rd_valid(rd_valid),
      .i_rd_data(rd_data),
      .o_rd_ready(rd_ready)
   );

   // Pulses last one cycle, so they are counted where they stand
   always @(posedge i_clk) begin
      if (rd_start === 1'b1) begin
         n_start <= n_start + 1;
         start_addr <= rd_addr;
      end
      if (frame_end === 1'b1) n_end <= n_end + 1;
      if (underrun === 1'b1) n_under <= n_under + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("errors %0d, comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Holds valid for up to 40 cycles; a refusal fails and ends the run unless the caller expects it
   task automatic push(input logic [7:0] b, input bit must, output bit ok);
      ok = 1'b0;
      @(posedge i_clk);
      rd_valid <= 1'b1;
      rd_data <= b;
      for (int k = 0; k < 40 && !ok; k++) begin
         @(posedge i_clk);
         ok = (rd_ready === 1'b1);
      end
      rd_valid <= 1'b0;
      if (!ok && must) begin
         n_errors++;
         end_sim();
      end
   endtask

   // The stream is loaded while the host stalls before the address, then read back one byte past its end
   task automatic read_frame(input logic [7:0] op, input bit mode3, input bit cont, input logic [23:0] addr,
                             input logic [7:0] mbits, input int nb);
      int la;
      int ld;
      int nd;
      logic [31:0] d;
      bit ok;
      int s0;
      int e0;
      int u0;
      la = (op == sfe_pkg::OP_DUAL_IO) ? 2 : (op == sfe_pkg::OP_QUAD_IO) ? 4 : 1;
      ld = (op inside {sfe_pkg::OP_DUAL_OUT, sfe_pkg::OP_DUAL_IO}) ? 2 : 1;
      ld = (op inside {sfe_pkg::OP_QUAD_OUT, sfe_pkg::OP_QUAD_IO}) ? 4 : ld;
      nd = (op == sfe_pkg::OP_READ || op == sfe_pkg::OP_DUAL_IO) ? 0 : (op == sfe_pkg::OP_QUAD_IO) ? 4 : 8;
      // The counters belong to the monitor; scenarios only take a baseline
      s0 = n_start;
      e0 = n_end;
      u0 = n_under;
      sfe_host_model_inst.start(mode3);
      if (!cont) sfe_host_model_inst.xfer(1, 8, 32'(op), d);
      for (int k = 0; k < nb; k++) push(8'h5A ^ 8'(k * 37), 1'b1, ok);
      if (nb == DEPTH) begin
         push(8'hEE, 1'b0, ok);
         check(32'(ok), 32'h0);
         check(32'(rd_ready), 32'h0);
      end
      sfe_host_model_inst.xfer(la, 24, 32'(addr), d);
      if (la > 1) sfe_host_model_inst.xfer(la, 8, 32'(mbits), d);
      if (nd > 0) sfe_host_model_inst.xfer(1, nd, 32'h0, d);
      check(32'(io_oe), 32'h0);
      check(32'(n_start - s0), 32'h1);
      check(32'(start_addr), 32'(addr[18:0]));
      for (int k = 0; k <= nb; k++) begin
         sfe_host_model_inst.xfer(ld, 8, 32'h0, d);
         check(d, (k < nb) ? 32'(8'h5A ^ 8'(k * 37)) : 32'h0);
      end
      check(32'(io_oe), 32'((1 << ld) - 1) << (ld == 1));
      check(32'(n_under - u0), 32'h1);
      sfe_host_model_inst.stop(mode3);
      check(32'(io_oe), 32'h0);
      check(32'(n_end - e0), 32'h1);
   endtask

   task automatic t_reset();
      check(32'(io_oe), 32'h0);
      check(32'(rd_addr), 32'h0);
      check(32'(rd_ready), 32'h1);
   endtask

   // Every read form, both clock polarities, upper address bits set
   task automatic t_forms();
      logic [7:0] ops [6];
      ops = '{sfe_pkg::OP_READ, sfe_pkg::OP_FAST, sfe_pkg::OP_DUAL_OUT,
              sfe_pkg::OP_DUAL_IO, sfe_pkg::OP_QUAD_OUT, sfe_pkg::OP_QUAD_IO};
      for (int k = 0; k < 6; k++) begin
         read_frame(ops[k], 1'(k), 1'b0, {5'h1F, 19'(k * 24'h012345)}, 8'h00, 3);
      end
   endtask

   task automatic t_continuous();
      read_frame(sfe_pkg::OP_QUAD_IO, 1'b0, 1'b0, 24'h012345, 8'h20, 2);
      read_frame(sfe_pkg::OP_QUAD_IO, 1'b1, 1'b1, 24'h054321, 8'hA0, 2);
      read_frame(sfe_pkg::OP_QUAD_IO, 1'b0, 1'b1, 24'h0ABCDE, 8'h00, 1);
      read_frame(sfe_pkg::OP_DUAL_IO, 1'b0, 1'b0, 24'hFFFFFF, 8'hE0, 1);
      read_frame(sfe_pkg::OP_DUAL_IO, 1'b1, 1'b1, 24'h000000, 8'h10, 1);
      read_frame(sfe_pkg::OP_READ, 1'b0, 1'b0, 24'h000010, 8'h00, 1);
   endtask

   // A valid read command hidden after a bad opcode must stay ignored
   task automatic t_unsupported();
      logic [7:0] bad [3];
      int s0;
      logic [31:0] d;
      bad = '{8'h02, 8'h9F, 8'hFF};
      for (int k = 0; k < 3; k++) begin
         s0 = n_start;
         sfe_host_model_inst.start(1'(k));
         sfe_host_model_inst.xfer(1, 8, 32'(bad[k]), d);
         sfe_host_model_inst.xfer(1, 32, {sfe_pkg::OP_READ, 24'h000100}, d);
         sfe_host_model_inst.xfer(1, 16, 32'h0, d);
         check(32'(io_oe), 32'h0);
         check(32'(n_start - s0), 32'h0);
         sfe_host_model_inst.stop(1'(k));
      end
   endtask

   task automatic t_abort();
      logic [31:0] d;
      int s0;
      s0 = n_start;
      sfe_host_model_inst.start(1'b1);
      sfe_host_model_inst.xfer(1, 4, 32'h0, d);
      sfe_host_model_inst.stop(1'b1);
      sfe_host_model_inst.start(1'b0);
      sfe_host_model_inst.xfer(1, 8, 32'(sfe_pkg::OP_FAST), d);
      sfe_host_model_inst.xfer(1, 20, 32'h0, d);
      sfe_host_model_inst.stop(1'b0);
      check(32'(n_start - s0), 32'h0);
      read_frame(sfe_pkg::OP_READ, 1'b0, 1'b0, 24'h07FFFF, 8'h00, 2);
   endtask

   // A full buffer refuses one more byte and still streams every stored byte in order
   task automatic t_full();
      read_frame(sfe_pkg::OP_FAST, 1'b0, 1'b0, 24'h03FF00, 8'h00, DEPTH);
   endtask

   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (6) @(posedge i_clk);
      t_reset();
      t_forms();
      t_continuous();
      t_unsupported();
      t_abort();
      t_full();
      end_sim();
   end
endmodule
